// ==== core/ebh_bus_ctl.sv ====
`timescale 1ns/100ps
module ebh_bus_ctl #(
   parameter int RAM_WORDS = ebh_pkg::RAM_WORDS
) (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RESET,
   // core request side
   input wire logic REQ_VALID,
   input wire ebh_pkg::ebh_req_t REQ,
   output logic REQ_READY,
   output logic REQ_DONE,
   output logic [ebh_pkg::DATA_W-1:0] REQ_RDATA,
   // core access to on-chip ram
   input wire logic LOC_EN,
   input wire logic LOC_WE,
   input wire logic [$clog2(RAM_WORDS)-1:0] LOC_ADDR,
   input wire logic [ebh_pkg::DATA_W-1:0] LOC_WDATA,
   output logic [ebh_pkg::DATA_W-1:0] LOC_RDATA,
   output logic LOC_BUSY,
   // bus control inputs
   input wire logic HOLD_N,
   input wire logic OFF_N,
   input wire logic READY,
   // address and data pins
   input wire logic [ebh_pkg::ADDR_W-1:0] A_IN,
   output logic [ebh_pkg::ADDR_W-1:0] A_OUT,
   output logic A_OE,
   input wire logic [ebh_pkg::DATA_W-1:0] D_IN,
   output logic [ebh_pkg::DATA_W-1:0] D_OUT,
   output logic D_OE,
   // strobe pins
   output ebh_pkg::ebh_pin_t WE_N,
   output ebh_pkg::ebh_pin_t RD_N,
   output ebh_pkg::ebh_pin_t PS_N,
   output ebh_pkg::ebh_pin_t DS_N,
   output ebh_pkg::ebh_pin_t IS_N,
   input wire logic RW_IN,
   output ebh_pkg::ebh_pin_t RW,
   input wire logic ACCESS_STROBE_N_IN,
   output ebh_pkg::ebh_pin_t ACCESS_STROBE_N,
   // ownership pins
   output ebh_pkg::ebh_pin_t BUS_GRANT_ACK_N,
   input wire logic GLOBAL_BUS_REQUEST_N_IN,
   output ebh_pkg::ebh_pin_t GLOBAL_BUS_REQUEST_N,
   output ebh_pkg::ebh_pin_t INSTR_FETCH_FLAG_N
);
   localparam int RAM_AW = $clog2(RAM_WORDS);

   ebh_pkg::ebh_state_t state_q, state_d;
   ebh_pkg::ebh_req_t req_q, req_d;
   logic [ebh_pkg::DATA_W-1:0] rdata_q, rdata_d;
   logic done_q, done_d;

   logic in_hold;
   logic in_xfer;
   logic is_global;
   logic drive_ok;
   logic dma_ack;
   logic dma_sel;
   logic ram_en;
   logic ram_we;
   logic [RAM_AW-1:0] ram_addr;
   logic [ebh_pkg::DATA_W-1:0] ram_wdata;
   logic [ebh_pkg::DATA_W-1:0] ram_rdata;
   logic dma_rd_q, dma_rd_d;

   assign in_hold = (state_q == ebh_pkg::ST_HOLD);
   assign in_xfer = (state_q == ebh_pkg::ST_XFER);
   assign is_global = (req_q.space == ebh_pkg::SPACE_GLOBAL);
   // pins gated by drive_ok float in hold or while float is low; grant and fetch flag only while float is low; dma read data unless a granted read
   assign drive_ok = OFF_N && !in_hold;
   // an outside master pulls the request pin low under grant
   assign dma_ack = in_hold && (GLOBAL_BUS_REQUEST_N_IN == ebh_pkg::PIN_ACTIVE);
   assign dma_sel = dma_ack && (ACCESS_STROBE_N_IN == ebh_pkg::PIN_ACTIVE);

   // bus ownership and transfer sequencing
   always_comb begin
      state_d = state_q;
      req_d = req_q;
      rdata_d = rdata_q;
      done_d = 1'b0;
      unique case (state_q)
         ebh_pkg::ST_IDLE: begin
            // hold wins over a waiting core request; the core just stalls
            if (!HOLD_N) begin
               state_d = ebh_pkg::ST_HOLD;
            end else if (REQ_VALID) begin
               req_d = REQ;
               if (REQ.space == ebh_pkg::SPACE_GLOBAL) begin
                  req_d.addr = {1'b0, REQ.addr[ebh_pkg::GLOBAL_AW-1:0]};
               end
               state_d = ebh_pkg::ST_XFER;
            end
         end
         ebh_pkg::ST_XFER: begin
            // low ready holds the cycle, it is sampled again next edge
            if (READY) begin
               rdata_d = req_q.write ? rdata_q : D_IN;
               done_d = 1'b1;
               state_d = ebh_pkg::ST_IDLE;
            end
         end
         ebh_pkg::ST_HOLD: begin
            if (HOLD_N) begin
               state_d = ebh_pkg::ST_IDLE;
            end
         end
         default: begin
            state_d = ebh_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         state_q <= ebh_pkg::ST_IDLE;
         req_q <= '0;
         rdata_q <= '0;
         done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         req_q <= req_d;
         rdata_q <= rdata_d;
         done_q <= done_d;
      end
   end

   assign REQ_READY = (state_q == ebh_pkg::ST_IDLE) && HOLD_N;
   assign REQ_DONE = done_q;
   assign REQ_RDATA = rdata_q;

   // outside master reads and writes the ram through the pins
   assign ram_en = dma_sel || (LOC_EN && !dma_ack);
   assign ram_we = dma_sel ? !RW_IN : LOC_WE;
   assign ram_addr = dma_sel ? A_IN[RAM_AW-1:0] : LOC_ADDR;
   assign ram_wdata = dma_sel ? D_IN : LOC_WDATA;
   assign LOC_BUSY = dma_ack;
   assign LOC_RDATA = ram_rdata;
   assign dma_rd_d = dma_sel && RW_IN;

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         dma_rd_q <= 1'b0;
      end else begin
         dma_rd_q <= dma_rd_d;
      end
   end

   ebh_ram #(
      .WORDS(RAM_WORDS),
      .DW(ebh_pkg::DATA_W)
   ) u_ram (
      .clk(REF_CLK),
      .en(ram_en),
      .we(ram_we),
      .addr(ram_addr),
      .wdata(ram_wdata),
      .rdata(ram_rdata)
   );

   // pin drive
   assign A_OUT = req_q.addr;
   assign A_OE = drive_ok && in_xfer;
   // write data and write strobe start in the same cycle
   assign D_OUT = dma_rd_q ? ram_rdata : req_q.wdata;
   assign D_OE = (drive_ok && in_xfer && req_q.write) || (OFF_N && dma_rd_q && dma_ack);
   assign WE_N.val = !(in_xfer && req_q.write);
   assign WE_N.oe = drive_ok;
   assign RD_N.val = !(in_xfer && !req_q.write);
   assign RD_N.oe = drive_ok;
   assign PS_N.val = !(in_xfer && req_q.space == ebh_pkg::SPACE_PROG);
   assign PS_N.oe = drive_ok;
   assign DS_N.val = !(in_xfer && (req_q.space == ebh_pkg::SPACE_DATA || is_global));
   assign DS_N.oe = drive_ok;
   assign IS_N.val = !(in_xfer && req_q.space == ebh_pkg::SPACE_IO);
   assign IS_N.oe = drive_ok;
   assign RW.val = !(in_xfer && req_q.write);
   assign RW.oe = drive_ok;
   assign ACCESS_STROBE_N.val = !in_xfer;
   assign ACCESS_STROBE_N.oe = drive_ok;
   assign BUS_GRANT_ACK_N.val = !in_hold;
   assign BUS_GRANT_ACK_N.oe = OFF_N;
   // released in hold so the outside master can drive it
   assign GLOBAL_BUS_REQUEST_N.val = !(in_xfer && is_global);
   assign GLOBAL_BUS_REQUEST_N.oe = drive_ok;
   // under grant the pin stops marking fetches and acknowledges instead
   assign INSTR_FETCH_FLAG_N.val = in_hold ? !dma_ack : !(in_xfer && req_q.fetch);
   assign INSTR_FETCH_FLAG_N.oe = OFF_N;

   // checks
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RESET);

   a_we_with_data: assert property (
      $fell(WE_N.val) && WE_N.oe |-> D_OE && $rose(D_OE) && D_OUT == req_q.wdata)
      else $error("write strobe fell without data drive");
   a_we_every_write: assert property (
      REQ_READY && REQ_VALID && REQ.write |=> !WE_N.val && RW.val == 1'b0)
      else $error("write cycle without write strobe");
   a_we_float: assert property (
      (in_hold || !OFF_N) |-> !WE_N.oe)
      else $error("write strobe driven in hold or float");
   a_hold_release: assert property (
      !HOLD_N && REQ_READY == 1'b0 && state_q == ebh_pkg::ST_IDLE |=>
      !A_OE && !RD_N.oe && !ACCESS_STROBE_N.oe && !GLOBAL_BUS_REQUEST_N.oe)
      else $error("lines still driven after hold taken");
   a_grant_level: assert property (
      $rose(in_hold) && OFF_N |-> BUS_GRANT_ACK_N.oe && !BUS_GRANT_ACK_N.val && !A_OE)
      else $error("grant not shown on hold entry");
   a_grant_float: assert property (
      !OFF_N |-> !BUS_GRANT_ACK_N.oe && !INSTR_FETCH_FLAG_N.oe)
      else $error("grant or fetch flag driven while float low");
   // every accepted or still waiting global cycle keeps the request low one more cycle
   a_global_req: assert property (
      (REQ_READY && REQ_VALID && REQ.space == ebh_pkg::SPACE_GLOBAL) ||
      (in_xfer && is_global && !READY) |=>
      !GLOBAL_BUS_REQUEST_N.val && (GLOBAL_BUS_REQUEST_N.oe == OFF_N))
      else $error("global request not held across access");
   a_global_float: assert property (
      !OFF_N |-> !GLOBAL_BUS_REQUEST_N.oe)
      else $error("global request driven while float low");
   a_dma_ack: assert property (
      in_hold && OFF_N |-> INSTR_FETCH_FLAG_N.val == GLOBAL_BUS_REQUEST_N_IN)
      else $error("fetch flag does not track ram request under grant");
   a_fetch_flag: assert property (
      !in_hold && !INSTR_FETCH_FLAG_N.val |-> in_xfer && req_q.fetch && A_OE == OFF_N)
      else $error("fetch flag without fetch address");
   a_ready_wait: assert property (
      in_xfer && !READY |=> in_xfer && !REQ_DONE)
      else $error("transfer ended with ready low");
   a_ready_done: assert property (
      in_xfer && READY |=> REQ_DONE && !in_xfer ##1 !REQ_DONE)
      else $error("transfer not completed on ready");
   a_dma_write: assert property (
      dma_sel && !RW_IN |-> ram_en && ram_we && ram_addr == A_IN[RAM_AW-1:0])
      else $error("external ram write not taken from pins");
   a_hold_exit: assert property (
      in_hold && HOLD_N |=> BUS_GRANT_ACK_N.val && (WE_N.oe == OFF_N))
      else $error("grant kept after hold removed");

   c_write_done: cover property (REQ_VALID && REQ_READY && REQ.write ##[1:6] REQ_DONE);
   c_global_wait: cover property (in_xfer && is_global && !READY ##1 !READY ##1 READY);
   c_hold_entry: cover property ($rose(in_hold) ##[1:8] $fell(in_hold));
   c_dma_read: cover property (dma_sel && RW_IN ##1 D_OE);
endmodule // ebh_bus_ctl

// ==== inc/ebh_pkg.sv ====
package ebh_pkg;

   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   // global data space reaches 32K words, so 15 address bits leave the pins
   localparam int GLOBAL_WORDS = 32768;
   localparam int GLOBAL_AW = $clog2(GLOBAL_WORDS);
   localparam int RAM_WORDS = 1024;

   typedef enum logic [1:0] {
      SPACE_PROG = 2'h0,
      SPACE_DATA = 2'h1,
      SPACE_IO = 2'h2,
      SPACE_GLOBAL = 2'h3
   } ebh_space_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_XFER = 3'h2,
      ST_HOLD = 3'h4
   } ebh_state_t;

   // one core request for an external bus cycle
   typedef struct packed {
      ebh_space_t space;
      logic write;
      logic fetch;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } ebh_req_t;

   // value and enable of one three-state control pin
   typedef struct packed {
      logic val;
      logic oe;
   } ebh_pin_t;

   localparam logic PIN_ACTIVE = 1'b0;
   localparam logic PIN_IDLE = 1'b1;

endpackage

// ==== core/ebh_ram.sv ====
`timescale 1ns/100ps
module ebh_ram #(
   parameter int WORDS = ebh_pkg::RAM_WORDS,
   parameter int DW = ebh_pkg::DATA_W
) (
   // clock
   input wire logic clk,
   // single port
   input wire logic en,
   input wire logic we,
   input wire logic [$clog2(WORDS)-1:0] addr,
   input wire logic [DW-1:0] wdata,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] mem [WORDS];
   logic [DW-1:0] rdata_q;

   // no reset on the array: contents are undefined until written
   always_ff @(posedge clk) begin
      if (en && we) begin
         mem[addr] <= wdata;
      end
      if (en && !we) begin
         rdata_q <= mem[addr];
      end
   end

   assign rdata = rdata_q;
endmodule // ebh_ram

// ==== dv/ebh_ext_mem.sv ====
`timescale 1ns/100ps
module ebh_ext_mem (
   // bus side
   input wire logic clk,
   input wire logic [3:0] waits,
   input wire ebh_pkg::ebh_pin_t we_n,
   input wire ebh_pkg::ebh_pin_t rd_n,
   input wire logic [15:0] d_out,
   // answers
   output logic ready,
   output logic mem_oe,
   output logic [15:0] mem_d,
   output logic [15:0] last_wr
);
   logic [3:0] cnt_q;
   logic act;
   assign act = (we_n.oe && !we_n.val) || (rd_n.oe && !rd_n.val);
   // ready only after the chosen number of wait cycles
   assign ready = cnt_q >= waits;
   assign mem_oe = rd_n.oe && !rd_n.val;
   assign mem_d = ~last_wr;
   always_ff @(posedge clk) begin
      cnt_q <= act ? cnt_q + 4'h1 : 4'h0;
      // the completion edge is where the write strobe rises
      if (we_n.oe && !we_n.val && ready) last_wr <= d_out;
   end
endmodule // ebh_ext_mem

// ==== dv/tb_external_bus_hold_and_dma_access.sv ====
`timescale 1ns/100ps
module tb_external_bus_hold_and_dma_access;
   logic clk, rst, req_valid, req_ready, req_done, hold_n, off_n, ready, mem_oe;
   logic loc_en, loc_we, loc_busy, a_oe, d_oe, tb_rw, tb_access_strobe_n, tb_gbr, tb_d_oe;
   logic [9:0] loc_addr;
   logic [15:0] loc_wdata, loc_rdata, req_rdata, a_out, d_out, tb_a, tb_d, d_in, mem_d, last_wr;
   logic [3:0] waits;
   ebh_pkg::ebh_req_t req;
   ebh_pkg::ebh_pin_t we_n, rd_n, ps_n, ds_n, is_n, rw, access_strobe_n, grant, gbr, instr_fetch_flag_n;
   int err_total, check_count, cyc, n;
   // released data lines toggle so a stale value never looks valid
   assign d_in = d_oe ? d_out : mem_oe ? mem_d : tb_d_oe ? tb_d : {16{clk}} ^ 16'hA5A5;
   ebh_bus_ctl u_ebh_bus_ctl (.REF_CLK(clk), .RESET(rst), .REQ_VALID(req_valid), .REQ(req),
      .REQ_READY(req_ready), .REQ_DONE(req_done), .REQ_RDATA(req_rdata), .LOC_EN(loc_en),
      .LOC_WE(loc_we), .LOC_ADDR(loc_addr), .LOC_WDATA(loc_wdata), .LOC_RDATA(loc_rdata),
      .LOC_BUSY(loc_busy), .HOLD_N(hold_n), .OFF_N(off_n), .READY(ready),
      .A_IN(a_oe ? a_out : tb_a), .A_OUT(a_out), .A_OE(a_oe), .D_IN(d_in), .D_OUT(d_out),
      .D_OE(d_oe), .WE_N(we_n), .RD_N(rd_n), .PS_N(ps_n), .DS_N(ds_n), .IS_N(is_n),
      .RW_IN(rw.oe ? rw.val : tb_rw), .RW(rw),
      .ACCESS_STROBE_N_IN(access_strobe_n.oe ? access_strobe_n.val : tb_access_strobe_n), .ACCESS_STROBE_N(access_strobe_n),
      .BUS_GRANT_ACK_N(grant), .GLOBAL_BUS_REQUEST_N_IN(gbr.oe ? gbr.val : tb_gbr),
      .GLOBAL_BUS_REQUEST_N(gbr), .INSTR_FETCH_FLAG_N(instr_fetch_flag_n));
   ebh_ext_mem u_ebh_ext_mem (.clk(clk), .waits(waits), .we_n(we_n), .rd_n(rd_n),
      .d_out(d_out), .ready(ready), .mem_oe(mem_oe), .mem_d(mem_d), .last_wr(last_wr));

   task automatic chk_bit(string nm, logic exp, logic got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %b seen %b", nm, exp, got);
      end
   endtask
   task automatic chk_word(string nm, logic [15:0] exp, logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task give_verdict;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // issue one request; returns in the first transfer cycle
   task automatic start_req(ebh_pkg::ebh_space_t s, logic w, logic f, logic [15:0] a);
      @(negedge clk);
      req_valid = 1'b1;
      req = '{space: s, write: w, fetch: f, addr: a, wdata: a ^ 16'h0F0F};
      chk_bit("req_ready", 1'b1, req_ready);
      @(negedge clk);
      req_valid = 1'b0;
   endtask
   task automatic wait_done;
      n = 1;
      while (req_done !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
   endtask

   task automatic t_writes;
      for (int s = 0; s < 4; s++) begin
         start_req(ebh_pkg::ebh_space_t'(s), 1'b1, 1'b0, 16'hFFFF);
         chk_bit("we low", 1'b0, we_n.val);
         chk_bit("d_oe", 1'b1, d_oe);
         chk_bit("rw write", 1'b0, rw.val);
         chk_bit("strobe", 1'b0, access_strobe_n.val);
         chk_bit("prog sel", s != 0, ps_n.val);
         chk_bit("data sel", s == 0 || s == 2, ds_n.val);
         chk_bit("io sel", s != 2, is_n.val);
         chk_bit("gbr", s != 3, gbr.val);
         chk_bit("gbr oe", 1'b1, gbr.oe);
         chk_word("addr", s == 3 ? 16'h7FFF : 16'hFFFF, a_out);
         wait_done;
         chk_word("write cycles", 16'(2), 16'(n));
         chk_bit("we high", 1'b1, we_n.val);
         chk_bit("d_oe off", 1'b0, d_oe);
         chk_word("latched", 16'hF0F0, last_wr);
      end
   endtask
   task automatic t_read_wait;
      waits = 4'h2;
      start_req(ebh_pkg::SPACE_DATA, 1'b0, 1'b1, 16'h0042);
      chk_bit("fetch flag", 1'b0, instr_fetch_flag_n.val);
      chk_bit("rd low", 1'b0, rd_n.val);
      chk_bit("rw read", 1'b1, rw.val);
      wait_done;
      chk_word("read cycles", 16'(4), 16'(n));
      chk_word("rdata", 16'h0F0F, req_rdata);
      waits = 4'h0;
   endtask
   task automatic t_hold_dma;
      @(negedge clk);
      {loc_en, loc_we, loc_addr, loc_wdata} = {2'b11, 10'h3FF, 16'h1234};
      @(negedge clk);
      {loc_en, hold_n} = 2'b00;
      @(negedge clk);
      chk_bit("grant", 1'b0, grant.val);
      chk_bit("we oe", 1'b0, we_n.oe);
      chk_bit("a_oe", 1'b0, a_oe);
      chk_bit("rd oe", 1'b0, rd_n.oe);
      tb_gbr = 1'b0;
      #1 chk_bit("ram ack", 1'b0, instr_fetch_flag_n.val);
      chk_bit("busy", 1'b1, loc_busy);
      @(negedge clk);
      {tb_access_strobe_n, tb_rw, tb_a, tb_d, tb_d_oe} = {2'b00, 16'h0005, 16'hBEEF, 1'b1};
      @(negedge clk);
      {tb_rw, tb_a, tb_d_oe} = {1'b1, 16'h03FF, 1'b0};
      @(negedge clk);
      tb_a = 16'h0005;
      chk_bit("dma d_oe", 1'b1, d_oe);
      chk_word("dma read", 16'h1234, d_out);
      @(negedge clk);
      chk_word("dma back", 16'hBEEF, d_out);
      {tb_access_strobe_n, tb_gbr, hold_n} = 3'b111;
      #1 chk_bit("ack gone", 1'b1, instr_fetch_flag_n.val);
      @(negedge clk);
      chk_bit("grant off", 1'b1, grant.val);
      chk_bit("we back", 1'b1, we_n.oe);
      {loc_en, loc_we, loc_addr} = {2'b10, 10'h005};
      @(negedge clk);
      loc_en = 1'b0;
      chk_word("core sees dma", 16'hBEEF, loc_rdata);
   endtask
   task automatic t_float;
      @(negedge clk);
      off_n = 1'b0;
      #1 chk_bit("we float", 1'b0, we_n.oe);
      chk_bit("grant float", 1'b0, grant.oe);
      chk_bit("gbr float", 1'b0, gbr.oe);
      @(negedge clk);
      off_n = 1'b1;
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // the whole run needs well under a hundred cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         err_total++;
         give_verdict;
      end
   end
   initial begin
      {rst, req_valid, loc_en, loc_we, tb_d_oe, waits} = '0;
      {hold_n, off_n, tb_rw, tb_access_strobe_n, tb_gbr} = '1;
      {loc_addr, loc_wdata, tb_a, tb_d} = '0;
      req = '0;
      rst = 1'b1;
      repeat (10) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      t_writes;
      t_read_wait;
      t_hold_dma;
      t_float;
      give_verdict;
   end
endmodule // tb_external_bus_hold_and_dma_access
